// file: tb_uart_fifo_line_format_ctrl.sv
`timescale 1ns/100ps

module tb_uart_fifo_line_format_ctrl;
    import ulf_pkg::*;
    logic       ref_clk;
    logic       rst_n;
    logic [2:0] addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic       rxd;
    logic       txd;
    logic       rts_n;
    logic       irq;
    logic [7:0] got_d;
    logic       got_p;
    logic       got_ok;
    int         fails = 0;
    int         checks_done = 0;

    ulf_uart dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rxd(rxd), .txd(txd),
        .rts_n(rts_n), .irq(irq));
    ulf_remote remote (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

    // 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle strobes launched just after a rising edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m,
                       input string what);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        check(what, exp & m, rd_data & m);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        addr = 3'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc(OFS_FIFO_CTRL, 8'h00, 8'hFF, "fifo_control reset");
        rdc(OFS_LINE_CTRL, 8'h00, 8'hFF, "line_control reset");
        wr(OFS_LINE_CTRL, 8'h9B);
        rdc(OFS_LINE_CTRL, 8'h9B, 8'hFF, "line_control");
        wr(OFS_FIFO_CTRL, 8'h47);
        rdc(OFS_FIFO_CTRL, 8'h41, 8'hFF, "fifo_control");
        rdc(3'h7, 8'h00, 8'hFF, "unmapped");
        wr(OFS_FLOW_CTRL, 8'h01);
        wr(OFS_INT_MASK, 8'h01);
        $display("test registers done");
        // both directions at once: a bad-parity char arrives while one leaves
        fork
            begin
                wr(OFS_DATA, 8'hA5);
                remote.get_char(got_d, got_p, got_ok);
            end
            remote.send_char(8'h3C, 1'b1);
        join
        #1;
        check("tx data", 8'hA5, got_d);
        check("tx parity", {7'h00, ^8'hA5}, {7'h00, got_p});
        check("tx framing", 8'h01, {7'h00, got_ok});
        check("irq below trigger", 8'h00, {7'h00, irq});
        check("rts below trigger", 8'h00, {7'h00, rts_n});
        remote.send_char(8'hC3, 1'b0);
        #1;
        check("irq at trigger", 8'h01, {7'h00, irq});
        check("rts at trigger", 8'h01, {7'h00, rts_n});
        rdc(OFS_INT_STATUS, 8'h05, 8'h07, "int_status");
        rdc(OFS_STATUS, 8'h2C, 8'hFF, "status two held");
        rdc(OFS_DATA, 8'h3C, 8'hFF, "rx data");
        rdc(OFS_STATUS, 8'h1D, 8'hFF, "status parity flag");
        wr(OFS_FIFO_CTRL, 8'h43);
        rdc(OFS_STATUS, 8'h00, 8'hF0, "count after flush");
        check("rts after flush", 8'h00, {7'h00, rts_n});
        check("irq after clear", 8'h00, {7'h00, irq});
        $display("test receive and transmit done");
        // seven bits, odd parity, two stops: the parity bit lands in data slot 7
        wr(OFS_LINE_CTRL, 8'h0E);
        wr(OFS_DATA, 8'h55);
        remote.get_char(got_d, got_p, got_ok);
        check("tx seven odd", 8'hD5, got_d);
        check("tx stop pair", 8'h03, {6'h00, got_p, got_ok});
        $display("test line format done");
        // queue flush leaves the character already in the shifter running
        wr(OFS_DATA, 8'h11);
        wr(OFS_DATA, 8'h22);
        wr(OFS_DATA, 8'h33);
        wr(OFS_FIFO_CTRL, 8'h45);
        rdc(OFS_STATUS, 8'h04, 8'h0C, "tx flush keeps shifter");
        wr(OFS_LINE_CTRL, 8'hDB);
        repeat (3) @(posedge ref_clk);
        #1;
        check("break level", 8'h00, {7'h00, txd});
        wr(OFS_LINE_CTRL, 8'h9B);
        $display("test flush and break done");
        final_report();
    end
endmodule // tb_uart_fifo_line_format_ctrl

// file: ulf_pkg.sv
package ulf_pkg;

    // clocking and bit timing
    localparam int         CLK_HZ       = 250_000_000;
    localparam int         BAUD_HZ      = 115_200;
    localparam int         BIT_CLKS     = CLK_HZ / BAUD_HZ;
    localparam int         HALF_CLKS    = BIT_CLKS / 2;
    localparam logic [11:0] BIT_LAST    = 12'(BIT_CLKS - 1);
    localparam logic [11:0] HALF_LAST   = 12'(HALF_CLKS - 1);
    localparam logic [5:0] TOUT_CHARS   = 6'h04;

    // register offsets on the 3-bit address port
    localparam logic [2:0] OFS_DATA       = 3'h0;
    localparam logic [2:0] OFS_FIFO_CTRL  = 3'h1;
    localparam logic [2:0] OFS_LINE_CTRL  = 3'h2;
    localparam logic [2:0] OFS_FLOW_CTRL  = 3'h3;
    localparam logic [2:0] OFS_STATUS     = 3'h4;
    localparam logic [2:0] OFS_INT_STATUS = 3'h5;
    localparam logic [2:0] OFS_INT_MASK   = 3'h6;

    // fifo_control fields
    localparam int FCR_TRIG_HI  = 7;
    localparam int FCR_TRIG_LO  = 6;
    localparam int FCR_TX_FLUSH = 2;
    localparam int FCR_RX_FLUSH = 1;
    localparam int FCR_QUEUE_EN = 0;

    // line_control fields
    localparam int LCR_SPARE    = 7;
    localparam int LCR_BREAK    = 6;
    localparam int LCR_PAR_HI   = 5;
    localparam int LCR_PAR_LO   = 4;
    localparam int LCR_PAR_EN   = 3;
    localparam int LCR_STOP2    = 2;
    localparam int LCR_LEN_HI   = 1;
    localparam int LCR_LEN_LO   = 0;

    // interrupt status / mask bits
    localparam int INT_RX_AVAIL = 0;
    localparam int INT_RX_TOUT  = 1;
    localparam int INT_RX_ERR   = 2;

    // reset values and sizes
    localparam logic [7:0] REG8_RESET  = 8'h00;
    localparam logic [3:0] QUEUE_DEPTH = 4'h8;
    localparam logic [3:0] SINGLE_SLOT = 4'h1;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
        TX_PAR  = 3'b011, TX_STOP  = 3'b100
    } ulf_tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
        RX_PAR  = 3'b011, RX_STOP  = 3'b100
    } ulf_rx_state_type;

    // receive threshold for a trigger code
    function automatic logic [3:0] ulf_trig_level(input logic [1:0] code);
        case (code)
            2'b00:   ulf_trig_level = 4'h1;
            2'b01:   ulf_trig_level = 4'h2;
            2'b10:   ulf_trig_level = 4'h4;
            default: ulf_trig_level = 4'h7;
        endcase
    endfunction

    // parity bit over the used data bits; format only counts when enabled
    function automatic logic ulf_parity(input logic [7:0] data, input logic [1:0] len,
                                        input logic [1:0] fmt);
        logic [7:0] used;
        used = data & (8'hFF >> (3'h3 - {1'b0, len}));
        case (fmt)
            2'b00:   ulf_parity = ~(^used);
            2'b01:   ulf_parity = ^used;
            2'b10:   ulf_parity = 1'b1;
            default: ulf_parity = 1'b0;
        endcase
    endfunction

    // bits per character: start, data, parity, stops
    function automatic logic [5:0] ulf_char_bits(input logic [7:0] lcr);
        // start, five data bits and the first stop always count
        ulf_char_bits = 6'h07 + {4'h0, lcr[LCR_LEN_HI:LCR_LEN_LO]}
                      + {5'h00, lcr[LCR_PAR_EN]} + {5'h00, lcr[LCR_STOP2]};
    endfunction

endpackage

// file: ulf_remote.sv
`timescale 1ns/100ps

module ulf_remote
    import ulf_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic txd,
    output logic      rxd
);
    // the line idles at mark between frames
    initial rxd = 1'b1;

    // start, 8 data lsb first, even parity, one stop
    task automatic send_char(input logic [7:0] d, input logic bad_par);
        logic [10:0] frame;
        frame = {1'b1, (^d) ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge ref_clk);
            rxd <= frame[i];
            repeat (BIT_CLKS - 1) @(posedge ref_clk);
        end
    endtask

    // sampled on the falling edge so the design's launch edge never races us
    task automatic get_char(output logic [7:0] d, output logic p, output logic ok);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (HALF_CLKS) @(negedge ref_clk);
        ok = (n < 1000) && (txd === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(negedge ref_clk);
            d[i] = txd;
        end
        repeat (BIT_CLKS) @(negedge ref_clk);
        p = txd;
        repeat (BIT_CLKS) @(negedge ref_clk);
        ok = ok && (txd === 1'b1);
    endtask
endmodule // ulf_remote

// file: ulf_uart.sv
// Behaviour
// - The trigger field picks a receive threshold of 1, 2, 4 or 7 bytes and resets to 00.
// - Reaching the threshold raises the data-available interrupt and, under flow control, drops RTS.
// - Writing the transmit flush bit empties the transmit queue but not the shifter, self-clearing.
// - Writing the receive flush bit empties the receive queue but not the shifter, self-clearing.
// - Queue enable gives eight bytes per direction, otherwise one byte with a one-byte trigger.
// - Line control bit 7 is a spare storage bit, reset to zero, with no effect on the line.
// - While force break is set the transmit line is held at space, and clearing it resumes.
// - Parity format selects odd, even, constant one or constant zero, used only with parity on.
// - Parity enable appends a parity bit on transmit and checks it on receive.
// - The stop setting sends one stop bit at zero and two stop bits at one.
// - The length field selects 5, 6, 7 or 8 data bits and resets to 00.
// - Under flow control RTS drops at the trigger level and comes back when the queue is empty.
// - More than four idle character periods with data waiting raise a timeout, cleared by a read.
// - A parity mismatch travels with its character and is reported when that character is read.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

module ulf_uart (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic       rxd,
    output logic            txd,
    output logic            rts_n,
    output logic            irq
);
    import ulf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // register state
    logic [1:0]       rx_trigger_level_q;
    logic             queue_enable_q;
    logic [7:0]       line_ctrl_q;
    logic             auto_flow_q;
    logic [2:0]       int_stat_q;
    logic [2:0]       int_mask_q;
    logic [7:0]       rd_data_q;
    logic             par_err_q;
    logic             frm_err_q;
    logic             txd_q;
    logic             rts_n_q;
    logic             irq_q;

    // address decode
    wire logic wr_data_reg = wr_en && (addr == OFS_DATA);
    wire logic wr_fifo_reg = wr_en && (addr == OFS_FIFO_CTRL);
    wire logic wr_line_reg = wr_en && (addr == OFS_LINE_CTRL);
    wire logic wr_flow_reg = wr_en && (addr == OFS_FLOW_CTRL);
    wire logic wr_mask_reg = wr_en && (addr == OFS_INT_MASK);
    wire logic rd_data_reg = rd_en && (addr == OFS_DATA);
    wire logic rd_istat    = rd_en && (addr == OFS_INT_STATUS);

    // line format fields
    wire logic [1:0] char_length   = line_ctrl_q[LCR_LEN_HI:LCR_LEN_LO];
    wire logic [1:0] parity_format = line_ctrl_q[LCR_PAR_HI:LCR_PAR_LO];
    wire logic       parity_enable = line_ctrl_q[LCR_PAR_EN];
    wire logic       two_stop_bits = line_ctrl_q[LCR_STOP2];
    wire logic       force_break   = line_ctrl_q[LCR_BREAK];
    wire logic [2:0] last_bit      = 3'h4 + {1'b0, char_length};

    wire logic [3:0] capacity  = queue_enable_q ? QUEUE_DEPTH : SINGLE_SLOT;
    wire logic [3:0] threshold = queue_enable_q ? ulf_trig_level(rx_trigger_level_q)
                                                : SINGLE_SLOT;

    // changing the mode empties both queues so stale depth never lingers
    wire logic mode_change = wr_fifo_reg && (wr_data[FCR_QUEUE_EN] != queue_enable_q);
    wire logic tx_flush    = (wr_fifo_reg && wr_data[FCR_TX_FLUSH]) || mode_change;
    wire logic rx_flush    = (wr_fifo_reg && wr_data[FCR_RX_FLUSH]) || mode_change;

    // control registers; flush bits are never stored, so they read as zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_trigger_level_q <= REG8_RESET[1:0];
            queue_enable_q     <= 1'b0;
            line_ctrl_q        <= REG8_RESET;
            auto_flow_q        <= 1'b0;
            int_mask_q         <= REG8_RESET[2:0];
        end else begin
            if (wr_fifo_reg) begin
                rx_trigger_level_q <= wr_data[FCR_TRIG_HI:FCR_TRIG_LO];
                queue_enable_q     <= wr_data[FCR_QUEUE_EN];
            end
            if (wr_line_reg) line_ctrl_q <= wr_data;
            if (wr_flow_reg) auto_flow_q <= wr_data[0];
            if (wr_mask_reg) int_mask_q  <= wr_data[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmit queue
    logic [7:0]       tx_mem [0:7];
    logic [2:0]       tx_wp_q;
    logic [2:0]       tx_rp_q;
    logic [3:0]       tx_cnt_q;
    ulf_tx_state_type tx_st_q;
    logic [11:0]      tx_baud_q;
    logic [2:0]       tx_bit_q;
    logic [7:0]       tx_shift_reg_q;
    logic             tx_par_q;
    logic             tx_stop2_q;

    wire logic tx_push = wr_data_reg && (tx_cnt_q < capacity);
    wire logic tx_pop  = (tx_st_q == TX_IDLE) && (tx_cnt_q != 4'h0);
    wire logic tx_tick = (tx_baud_q == BIT_LAST);

    always_ff @(posedge ref_clk) begin
        if (tx_push) tx_mem[tx_wp_q] <= wr_data;
    end

    // a flush drops queued bytes only; the shifter finishes its character
    always_ff @(posedge ref_clk) begin
        if (!rst_n || tx_flush) begin
            tx_wp_q  <= 3'h0;
            tx_rp_q  <= 3'h0;
            tx_cnt_q <= 4'h0;
        end else begin
            tx_wp_q  <= tx_wp_q + {2'h0, tx_push};
            tx_rp_q  <= tx_rp_q + {2'h0, tx_pop};
            tx_cnt_q <= tx_cnt_q + {3'h0, tx_push} - {3'h0, tx_pop};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_st_q        <= TX_IDLE;
            tx_baud_q      <= 12'h000;
            tx_bit_q       <= 3'h0;
            tx_shift_reg_q <= 8'h00;
            tx_par_q       <= 1'b0;
            tx_stop2_q     <= 1'b0;
        end else begin
            tx_baud_q <= (tx_tick || tx_st_q == TX_IDLE) ? 12'h000 : tx_baud_q + 12'h001;
            case (tx_st_q)
                TX_IDLE: begin
                    if (tx_pop) begin
                        tx_shift_reg_q <= tx_mem[tx_rp_q];
                        tx_par_q       <= ulf_parity(tx_mem[tx_rp_q], char_length,
                                                     parity_format);
                        tx_st_q        <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        tx_bit_q <= 3'h0;
                        tx_st_q  <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick && tx_bit_q == last_bit) begin
                        tx_stop2_q <= 1'b0;
                        tx_st_q    <= parity_enable ? TX_PAR : TX_STOP;
                    end else if (tx_tick) begin
                        tx_bit_q <= tx_bit_q + 3'h1;
                    end
                end
                TX_PAR: begin
                    if (tx_tick) tx_st_q <= TX_STOP;
                end
                TX_STOP: begin
                    if (tx_tick && two_stop_bits && !tx_stop2_q) begin
                        tx_stop2_q <= 1'b1;
                    end else if (tx_tick) begin
                        tx_st_q <= TX_IDLE;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // line level per state, idle high
    wire logic tx_level = (tx_st_q == TX_START) ? 1'b0 :
                          (tx_st_q == TX_DATA)  ? tx_shift_reg_q[tx_bit_q] :
                          (tx_st_q == TX_PAR)   ? tx_par_q : 1'b1;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) txd_q <= 1'b1;
        else        txd_q <= force_break ? 1'b0 : tx_level;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive path: entries hold {frame error, parity error, data}
    logic [9:0]       rx_mem [0:7];
    logic [2:0]       rx_wp_q;
    logic [2:0]       rx_rp_q;
    logic [3:0]       rx_cnt_q;
    ulf_rx_state_type rx_st_q;
    logic [11:0]      rx_baud_q;
    logic [2:0]       rx_bit_q;
    logic [7:0]       rx_shift_reg_q;
    logic             rx_perr_q;

    wire logic rx_tick  = (rx_baud_q == BIT_LAST);
    wire logic rx_half  = (rx_baud_q == HALF_LAST);
    wire logic rx_ferr  = ~rxd;
    // a full queue drops the new character rather than overwrite older data
    wire logic rx_push  = (rx_st_q == RX_STOP) && rx_tick && (rx_cnt_q < capacity);
    wire logic rx_pop   = rd_data_reg && (rx_cnt_q != 4'h0);
    wire logic [3:0] rx_cnt_d = rx_cnt_q + {3'h0, rx_push} - {3'h0, rx_pop};

    always_ff @(posedge ref_clk) begin
        if (rx_push) rx_mem[rx_wp_q] <= {rx_ferr, rx_perr_q, rx_shift_reg_q};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || rx_flush) begin
            rx_wp_q  <= 3'h0;
            rx_rp_q  <= 3'h0;
            rx_cnt_q <= 4'h0;
        end else begin
            rx_wp_q  <= rx_wp_q + {2'h0, rx_push};
            rx_rp_q  <= rx_rp_q + {2'h0, rx_pop};
            rx_cnt_q <= rx_cnt_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_st_q        <= RX_IDLE;
            rx_baud_q      <= 12'h000;
            rx_bit_q       <= 3'h0;
            rx_shift_reg_q <= 8'h00;
            rx_perr_q      <= 1'b0;
        end else begin
            rx_baud_q <= (rx_st_q == RX_IDLE || rx_tick || (rx_st_q == RX_START && rx_half))
                       ? 12'h000 : rx_baud_q + 12'h001;
            case (rx_st_q)
                RX_IDLE: begin
                    if (!rxd) rx_st_q <= RX_START;
                end
                RX_START: begin
                    // a glitch shorter than half a bit is not a start
                    if (rx_half) begin
                        rx_st_q        <= rxd ? RX_IDLE : RX_DATA;
                        rx_bit_q       <= 3'h0;
                        rx_shift_reg_q <= 8'h00;
                        rx_perr_q      <= 1'b0;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_shift_reg_q[rx_bit_q] <= rxd;
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == last_bit) begin
                            rx_st_q <= parity_enable ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_tick) begin
                        rx_perr_q <= rxd != ulf_parity(rx_shift_reg_q, char_length,
                                                       parity_format);
                        rx_st_q   <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_tick) rx_st_q <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timeout: count idle bit periods while data waits
    logic [11:0] tout_baud_q;
    logic [5:0]  tout_bits_q;

    wire logic       tout_tick  = (tout_baud_q == BIT_LAST);
    wire logic [5:0] tout_limit = 6'(TOUT_CHARS * ulf_char_bits(line_ctrl_q));
    wire logic       tout_hold  = rx_push || rx_pop || (rx_cnt_q == 4'h0) || (rx_st_q != RX_IDLE);
    wire logic       tout_evt   = tout_tick && !tout_hold && (tout_bits_q == tout_limit);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tout_baud_q <= 12'h000;
            tout_bits_q <= 6'h00;
        end else begin
            tout_baud_q <= (tout_tick || tout_hold) ? 12'h000 : tout_baud_q + 12'h001;
            if (tout_hold)                                tout_bits_q <= 6'h00;
            else if (tout_tick && tout_bits_q <= tout_limit) tout_bits_q <= tout_bits_q + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt events; a set in the clearing cycle wins
    // threshold crossing event
    wire logic avail_evt = (rx_cnt_d >= threshold) && (rx_cnt_q < threshold) && !rx_flush;
    wire logic err_evt   = rx_push && (rx_ferr || rx_perr_q);
    wire logic [2:0] int_set = {err_evt, tout_evt, avail_evt};
    wire logic [2:0] int_clr = rd_istat ? 3'h7 : {1'b0, rx_pop, 1'b0};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_stat_q <= 3'h0;
            irq_q      <= 1'b0;
        end else begin
            int_stat_q <= (int_stat_q & ~int_clr) | int_set;
            irq_q      <= |(int_stat_q & int_mask_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n)                     rts_n_q <= 1'b0;
        else if (!auto_flow_q)          rts_n_q <= 1'b0;
        else if (rx_cnt_q >= threshold) rts_n_q <= 1'b1;
        else if (rx_cnt_q == 4'h0)      rts_n_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe
    wire logic [9:0] rx_head     = (rx_cnt_q != 4'h0) ? rx_mem[rx_rp_q] : 10'h000;
    wire logic       tx_all_idle = (tx_cnt_q == 4'h0) && (tx_st_q == TX_IDLE);
    wire logic [7:0] rd_mux =
        (addr == OFS_DATA)       ? rx_head[7:0] :
        (addr == OFS_FIFO_CTRL)  ? {rx_trigger_level_q, 5'h00, queue_enable_q} :
        (addr == OFS_LINE_CTRL)  ? line_ctrl_q :
        (addr == OFS_FLOW_CTRL)  ? {7'h00, auto_flow_q} :
        (addr == OFS_STATUS)     ? {rx_cnt_q, tx_all_idle, tx_cnt_q == 4'h0, frm_err_q,
                                    par_err_q} :
        (addr == OFS_INT_STATUS) ? {5'h00, int_stat_q} :
        (addr == OFS_INT_MASK)   ? {5'h00, int_mask_q} : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
            par_err_q <= 1'b0;
            frm_err_q <= 1'b0;
        end else begin
            rd_data_q <= rd_en ? rd_mux : 8'h00;
            if (rx_pop) begin
                par_err_q <= rx_head[8];
                frm_err_q <= rx_head[9];
            end
        end
    end

    assign rd_data = rd_data_q;
    assign txd     = txd_q;
    assign rts_n   = rts_n_q;
    assign irq     = irq_q;

endmodule // ulf_uart

// file: ulf_uart_monitor.sv
`timescale 1ns/100ps

module ulf_uart_monitor
    import ulf_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    input wire logic       rxd,
    input wire logic       txd,
    input wire logic       rts_n,
    input wire logic       irq
);
    logic [7:0] lcr_q;
    logic [1:0] trig_q;
    logic       qen_q;
    logic       flow_q;
    logic [2:0] mask_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // shadows of the settings software wrote, so checks need no internal probes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lcr_q <= REG8_RESET;
            trig_q <= 2'h0;
            qen_q <= 1'b0;
            flow_q <= 1'b0;
            mask_q <= 3'h0;
        end else if (wr_en) begin
            if (addr == OFS_LINE_CTRL) lcr_q <= wr_data;
            if (addr == OFS_FIFO_CTRL) {trig_q, qen_q} <= {wr_data[7:6], wr_data[0]};
            if (addr == OFS_FLOW_CTRL) flow_q <= wr_data[0];
            if (addr == OFS_INT_MASK) mask_q <= wr_data[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flush command followed by a status read two cycles on
    sequence s_rx_flush;
        wr_en && addr == OFS_FIFO_CTRL && wr_data[FCR_RX_FLUSH];
    endsequence
    sequence s_stat_rd;
        rd_en && addr == OFS_STATUS;
    endsequence

    // reset holds the line idle and the outputs quiet, so no reset gating here
    a_reset_idle: assert property (disable iff (1'b0) !rst_n |=> txd && !irq)
        else $error("outputs not idle after reset");
    a_break_space: assert property (lcr_q[LCR_BREAK] [*2] |-> !txd)
        else $error("txd not at space while break forced");
    a_line_readback: assert property (rd_en && addr == OFS_LINE_CTRL |=> rd_data == $past(lcr_q))
        else $error("line_control readback differs");
    a_fifo_readback: assert property (rd_en && addr == OFS_FIFO_CTRL
        |=> rd_data == {$past(trig_q), 5'h00, $past(qen_q)})
        else $error("fifo_control readback differs");
    a_no_flow_rts: assert property ((!flow_q) [*2] |-> !rts_n)
        else $error("rts dropped without flow control");
    a_mask_quiet: assert property ((mask_q == 3'h0) [*2] |-> !irq)
        else $error("irq high with all sources masked");
    a_flush_count: assert property (s_rx_flush ##2 s_stat_rd |=> rd_data[7:4] == 4'h0)
        else $error("receive count not zero after flush");
    a_flush_rts: assert property (s_rx_flush ##0 flow_q |-> ##2 !rts_n)
        else $error("rts not reasserted after flush");
    a_depth_cap: assert property (s_stat_rd
        |=> rd_data[7:4] <= ($past(qen_q) ? QUEUE_DEPTH : SINGLE_SLOT))
        else $error("receive count beyond queue depth");
endmodule // ulf_uart_monitor

bind ulf_uart ulf_uart_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rxd(rxd),
    .txd(txd), .rts_n(rts_n), .irq(irq));
